// >>> rtl/tal_pkg.sv
// Shared constants and types for the thermal alarm logic
package tal_pkg;

   // ==========================================
   // Reading format
   localparam int TEMP_W = 9;
   localparam int QCNT_W = 3;

   // ==========================================
   // Queue depth codes and decoded conversion counts
   localparam logic [1:0] QSEL_ONE = 2'h0;
   localparam logic [1:0] QSEL_TWO = 2'h1;
   localparam logic [1:0] QSEL_FOUR = 2'h2;
   localparam logic [1:0] QSEL_SIX = 2'h3;
   localparam logic [QCNT_W-1:0] QDEPTH_ONE = 3'h1;
   localparam logic [QCNT_W-1:0] QDEPTH_TWO = 3'h2;
   localparam logic [QCNT_W-1:0] QDEPTH_FOUR = 3'h4;
   localparam logic [QCNT_W-1:0] QDEPTH_SIX = 3'h6;

   // ==========================================
   // Reset values and counter step
   localparam logic [TEMP_W-1:0] TEMP_RST = 9'h000;
   localparam logic [QCNT_W-1:0] QCNT_RST = 3'h0;
   localparam logic [QCNT_W-1:0] QCNT_STEP = 3'h1;

   // ==========================================
   // Condition indices
   localparam int COND_OVER = 0;
   localparam int COND_UNDER = 1;
   localparam int COND_N = 2;

   // Which crossing the interrupt logic is waiting for
   typedef enum logic {
      TAL_WAIT_OVER,
      TAL_WAIT_UNDER
   } tal_wait_t;

endpackage : tal_pkg

// >>> rtl/tal_alarm.sv
// Thermal alarm logic: threshold compare, fault queue, flag and alert pin
`timescale 1ns/1ps
// Summary of operation
// - Comparator: assert after depth readings above setpoint
// - Comparator: hold until depth readings below threshold
// - Comparator: sleep leaves alert unchanged
// - Interrupt: no automatic clear below threshold
// - After over event, wait for under crossing
// - After under event, wait for over crossing
// - Mode bit cleared then set: expect overtemp
// - Responds to overtemperature from power-up
// - Queue code: one, two, four, six conversions
// - Condition valid after depth consecutive conversions
// - Setup register read clears the flag
// - Single flag merges repeated events
// - Flag sets on every qualified condition in comparator mode, unmasked
// - Interrupt drives alert only unmasked, interrupt mode
// - Interrupt mode: any register read clears alert and flag
// - Sleep in interrupt mode clears alert, flag
// - Conversions keep running while alert asserted
// - Polarity bit: clear low-active, set high-active
// - Open-drain pin: sink low or float only
// - Mask set floats the pin
// - Hot at power-up sets flag after depth conversions
// - Signed nine-bit compare, half-degree units
// - Flag is read-only, one when event occurred
module tal_alarm (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic conv_valid,
   input wire logic [tal_pkg::TEMP_W-1:0] conv_data,
   input wire logic sleep_request,
   input wire logic cfg_mode,
   input wire logic alert_polarity,
   input wire logic alert_mask,
   input wire logic [1:0] cfg_queue,
   input wire logic [tal_pkg::TEMP_W-1:0] set_point,
   input wire logic [tal_pkg::TEMP_W-1:0] low_threshold,
   input wire logic cfg_read,
   input wire logic any_read,
   output logic alert_out,
   output logic alert_oe,
   output logic event_flag,
   output logic [tal_pkg::TEMP_W-1:0] temp_value
);

   // ==========================================
   // Decode functions
   function automatic logic [tal_pkg::QCNT_W-1:0] queue_depth(
      input logic [1:0] sel
   );
      logic [tal_pkg::QCNT_W-1:0] d;
      d = tal_pkg::QDEPTH_ONE;
      case (sel)
         tal_pkg::QSEL_ONE: d = tal_pkg::QDEPTH_ONE;
         tal_pkg::QSEL_TWO: d = tal_pkg::QDEPTH_TWO;
         tal_pkg::QSEL_FOUR: d = tal_pkg::QDEPTH_FOUR;
         tal_pkg::QSEL_SIX: d = tal_pkg::QDEPTH_SIX;
         default: d = tal_pkg::QDEPTH_ONE;
      endcase
      return d;
   endfunction : queue_depth

   function automatic logic signed_gt(
      input logic [tal_pkg::TEMP_W-1:0] a,
      input logic [tal_pkg::TEMP_W-1:0] b
   );
      return $signed(a) > $signed(b);
   endfunction : signed_gt

   // ==========================================
   // Link domain: hold the finished reading
   logic [tal_pkg::TEMP_W-1:0] link_data_ff;
   logic link_tgl_ff;
   wire [tal_pkg::TEMP_W-1:0] nxt_link_data =
      conv_valid ? conv_data : link_data_ff;
   // Toggle flips once per finished conversion
   wire nxt_link_tgl = conv_valid ? ~link_tgl_ff : link_tgl_ff;

   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         link_data_ff <= tal_pkg::TEMP_RST;
      end else begin
         link_data_ff <= nxt_link_data;
      end
   end

   // Level change carries the event across
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         link_tgl_ff <= 1'b0;
      end else begin
         link_tgl_ff <= nxt_link_tgl;
      end
   end

   // ==========================================
   // Crossing into mclk: toggle synchroniser
   logic tgl_meta_ff;
   logic tgl_sync_ff;
   logic tgl_seen_ff;

   // First stage, read only by the second
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tgl_meta_ff <= 1'b0;
      end else begin
         tgl_meta_ff <= link_tgl_ff;
      end
   end

   // Second stage settles the level
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tgl_sync_ff <= 1'b0;
      end else begin
         tgl_sync_ff <= tgl_meta_ff;
      end
   end

   // Previous level for change detection
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tgl_seen_ff <= 1'b0;
      end else begin
         tgl_seen_ff <= tgl_sync_ff;
      end
   end

   // One mclk pulse per finished conversion
   wire conv_evt = tgl_sync_ff ^ tgl_seen_ff;

   // ==========================================
   // Crossing into mclk: hold the reading
   logic [tal_pkg::TEMP_W-1:0] cap_data_ff;
   logic cap_vld_ff;
   // Link data has been quiet for two mclk edges when the pulse lands
   wire [tal_pkg::TEMP_W-1:0] nxt_cap_data =
      conv_evt ? link_data_ff : cap_data_ff;
   // Conversions are dropped while asleep
   wire nxt_cap_vld = conv_evt & ~sleep_request;

   // Reading moves into mclk only on the pulse
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cap_data_ff <= tal_pkg::TEMP_RST;
      end else begin
         cap_data_ff <= nxt_cap_data;
      end
   end

   // Marks a held reading ready for evaluation
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cap_vld_ff <= 1'b0;
      end else begin
         cap_vld_ff <= nxt_cap_vld;
      end
   end

   // A sleep request that arrives meanwhile still drops the reading
   wire conv_use = cap_vld_ff & ~sleep_request;
   wire [tal_pkg::TEMP_W-1:0] new_temp = cap_data_ff;

   // ==========================================
   // Threshold comparison and fault queue
   // depth decode
   wire [tal_pkg::QCNT_W-1:0] depth = queue_depth(cfg_queue);
   wire [tal_pkg::COND_N-1:0] cond_hit;
   wire [tal_pkg::COND_N-1:0] cond_qual;

   assign cond_hit[tal_pkg::COND_OVER] = signed_gt(new_temp, set_point);
   assign cond_hit[tal_pkg::COND_UNDER] =
      signed_gt(low_threshold, new_temp);

   genvar gi;
   generate
      for (gi = 0; gi < tal_pkg::COND_N; gi++) begin : g_queue
         logic [tal_pkg::QCNT_W-1:0] cnt_ff;
         wire [tal_pkg::QCNT_W-1:0] cnt_inc =
            (cnt_ff >= depth) ? depth : cnt_ff + tal_pkg::QCNT_STEP;
         wire [tal_pkg::QCNT_W-1:0] nxt_cnt =
            cond_hit[gi] ? cnt_inc : tal_pkg::QCNT_RST;
         assign cond_qual[gi] = conv_use & cond_hit[gi] &
            (cnt_inc >= depth);
         // counter moves only on a used conversion
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               cnt_ff <= tal_pkg::QCNT_RST;
            end else if (conv_use) begin
               cnt_ff <= nxt_cnt;
            end
         end
      end
   endgenerate

   wire over_q = cond_qual[tal_pkg::COND_OVER];
   wire under_q = cond_qual[tal_pkg::COND_UNDER];

   // ==========================================
   // Comparator and interrupt state
   logic cmp_ff;
   logic int_ff;
   logic flag_ff;
   logic mode_ff;
   logic sleep_ff;
   tal_pkg::tal_wait_t wait_ff;
   tal_pkg::tal_wait_t nxt_wait;

   wire mode_rise = cfg_mode & ~mode_ff;
   wire sleep_rise = sleep_request & ~sleep_ff;
   // interrupt event only on the awaited crossing
   wire int_evt = (wait_ff == tal_pkg::TAL_WAIT_OVER) ? over_q : under_q;
   // comparator sets on every qualified condition
   wire flag_set = cfg_mode ? int_evt : (over_q | under_q);
   wire flag_clr = cfg_read | (cfg_mode & (any_read | sleep_rise));
   wire int_clr = any_read | sleep_rise;

   always_comb begin
      nxt_wait = wait_ff;
      case (wait_ff)
         tal_pkg::TAL_WAIT_OVER:
            if (cfg_mode & over_q) nxt_wait = tal_pkg::TAL_WAIT_UNDER;
         tal_pkg::TAL_WAIT_UNDER:
            if (cfg_mode & under_q) nxt_wait = tal_pkg::TAL_WAIT_OVER;
         default: nxt_wait = tal_pkg::TAL_WAIT_OVER;
      endcase
      if (mode_rise) begin
         nxt_wait = tal_pkg::TAL_WAIT_OVER;
      end
   end

   // Crossing the interrupt logic waits for
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wait_ff <= tal_pkg::TAL_WAIT_OVER;
      end else begin
         wait_ff <= nxt_wait;
      end
   end

   // Previous mode level for the override edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode_ff <= 1'b0;
      end else begin
         mode_ff <= cfg_mode;
      end
   end

   // Previous sleep level; only entering sleep clears
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sleep_ff <= 1'b0;
      end else begin
         sleep_ff <= sleep_request;
      end
   end

   // ==========================================
   // Alarm state next values
   // Thermostat sets on over and clears on under
   wire cmp_set = over_q;
   wire cmp_clr = under_q;
   // Latched interrupt only arms in interrupt behaviour
   wire int_set = cfg_mode & int_evt;
   wire nxt_cmp = cmp_set ? 1'b1 : (cmp_clr ? 1'b0 : cmp_ff);
   // latched interrupt; set wins over clear
   wire nxt_int = int_set ? 1'b1 : (int_clr ? 1'b0 : int_ff);
   // single sticky flag; set wins over clear
   wire nxt_flag = flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_ff);

   // Thermostat level
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cmp_ff <= 1'b0;
      end else begin
         cmp_ff <= nxt_cmp;
      end
   end

   // Interrupt latch, held until read or sleep
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         int_ff <= 1'b0;
      end else begin
         int_ff <= nxt_int;
      end
   end

   // Status flag seen by the host
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // ==========================================
   // Alert pin and outputs
   // interrupt path requires interrupt mode
   wire asserted = cfg_mode ? int_ff : cmp_ff;
   // sink when low-active asserted or high-active idle
   wire nxt_oe = ~alert_mask & (asserted ^ alert_polarity);

   logic oe_ff;
   logic [tal_pkg::TEMP_W-1:0] temp_ff;
   // Dropped readings leave the last used value in place
   wire [tal_pkg::TEMP_W-1:0] nxt_temp = conv_use ? new_temp : temp_ff;

   // Pin enable comes from a flop so the pin never glitches
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= nxt_oe;
      end
   end

   // Last reading used for evaluation
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         temp_ff <= tal_pkg::TEMP_RST;
      end else begin
         temp_ff <= nxt_temp;
      end
   end

   logic low_ff;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         low_ff <= 1'b0;
      end else begin
         low_ff <= 1'b0;
      end
   end

   assign alert_out = low_ff;
   assign alert_oe = oe_ff;
   assign event_flag = flag_ff;
   assign temp_value = temp_ff;

endmodule : tal_alarm

// >>> dv/tal_alarm_chk.sv
// Port assertions for the thermal alarm logic
`timescale 1ns/1ps
module tal_alarm_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sleep_request,
   input wire logic cfg_mode,
   input wire logic alert_polarity,
   input wire logic alert_mask,
   input wire logic cfg_read,
   input wire logic any_read,
   input wire logic alert_out,
   input wire logic alert_oe,
   input wire logic event_flag
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // ==========
   // Assertions
   pin_low_only_a: assert property (alert_out == 1'b0)
      else $error("alert pin driven high");
   mask_float_a: assert property (alert_mask && $past(alert_mask) |-> !alert_oe)
      else $error("masked pin not floating");
   read_clear_a: assert property (cfg_read |=> !event_flag)
      else $error("setup read left flag set");
   any_read_clear_a: assert property (cfg_mode && any_read |=> !event_flag)
      else $error("register read left flag set");
   sleep_clear_a: assert property (cfg_mode && $rose(sleep_request) |=> !event_flag)
      else $error("sleep left flag set");
   comp_sleep_a: assert property (!cfg_mode && sleep_request &&
      $past(sleep_request, 2) && $stable(cfg_mode) && $stable(alert_mask) &&
      $stable(alert_polarity) |-> $stable(alert_oe))
      else $error("sleep changed comparator output");
   int_flag_a: assert property (cfg_mode && $past(cfg_mode) &&
      $past(cfg_mode, 2) && !alert_polarity && $rose(alert_oe) |-> $past(event_flag))
      else $error("interrupt without flag");
   pol_flip_a: assert property ($changed(alert_polarity) && !alert_mask &&
      $stable(alert_mask) |-> ##1 $changed(alert_oe))
      else $error("polarity change ignored");
   cover property (cfg_mode && $rose(alert_oe));
   cover property (!cfg_mode && $rose(alert_oe));
   cover property (alert_polarity && $fell(alert_oe));
endmodule : tal_alarm_chk
bind tal_alarm tal_alarm_chk u_chk (.mclk, .rst_n, .sleep_request, .cfg_mode,
   .alert_polarity, .alert_mask, .cfg_read, .any_read, .alert_out, .alert_oe,
   .event_flag);

// >>> dv/tal_conv_src.sv
// Conversion source model on the link clock
`timescale 1ns/1ps
module tal_conv_src (
   output logic conv_valid,
   output logic [8:0] conv_data,
   input wire logic link_clk
);
   initial begin
      conv_valid = 1'b0;
      conv_data = 9'h155;
   end
   // Idle data shows the inverse of the last reading
   task automatic send(input logic [8:0] v);
      @(posedge link_clk);
      #2;
      conv_valid = 1'b1;
      conv_data = v;
      @(posedge link_clk);
      #2;
      conv_valid = 1'b0;
      conv_data = ~v;
      repeat (5) @(posedge link_clk);
   endtask : send
endmodule : tal_conv_src

// >>> dv/testbench.sv
// Testbench for the thermal alarm logic
`timescale 1ns/1ps
module testbench;
   localparam logic [8:0] HOT = 9'h0A2;
   localparam logic [8:0] MID = 9'h09B;
   localparam logic [8:0] COLD = 9'h1CE;
   logic mclk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
   logic sleep_request = 1'b0, cfg_mode = 1'b0, alert_polarity = 1'b0;
   logic alert_mask = 1'b0, cfg_read = 1'b0, any_read = 1'b0;
   logic [1:0] cfg_queue = 2'h0;
   logic [8:0] set_point = 9'h0A0, low_threshold = 9'h096;
   logic conv_valid, alert_out, alert_oe, event_flag;
   logic [8:0] conv_data, temp_value;
   int err_total = 0, cmp_count = 0;
   always #25 mclk = ~mclk;
   initial #13 forever #40 link_clk = ~link_clk;
   tal_conv_src CS (.conv_valid, .conv_data, .link_clk);
   tal_alarm DUT (.mclk, .rst_n, .link_clk, .link_rst_n(rst_n), .conv_valid,
      .conv_data, .sleep_request, .cfg_mode, .alert_polarity, .alert_mask,
      .cfg_queue, .set_point, .low_threshold, .cfg_read, .any_read,
      .alert_out, .alert_oe, .event_flag, .temp_value);
   // ==========
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : cyc
   task automatic chk(input logic [8:0] e, input logic [8:0] a);
      cmp_count++;
      if (e !== a) begin
         err_total++;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask : chk
   task automatic conv(input logic [8:0] v);
      CS.send(v);
      cyc(1);
      if (!sleep_request) chk(v, temp_value);
   endtask : conv
   task automatic rd(input logic c);
      cfg_read = c;
      any_read = 1'b1;
      cyc(1);
      cfg_read = 1'b0;
      any_read = 1'b0;
      cyc(2);
   endtask : rd
   // ==========
   // Scenarios
   task automatic t_queue;
      int d[4] = '{1, 2, 4, 6};
      for (int q = 0; q < 4; q++) begin
         cfg_queue = q[1:0];
         repeat (d[q] - 1) conv(HOT);
         chk(1'b0, alert_oe);
         conv(HOT);
         chk(1'b1, alert_oe);
         chk(1'b1, event_flag);
         rd(1'b1);
         chk(1'b0, event_flag);
         repeat (d[q] - 1) conv(COLD);
         chk(1'b1, alert_oe);
         conv(COLD);
         chk(1'b0, alert_oe);
         rd(1'b1);
      end
   endtask : t_queue
   task automatic t_run_reset;
      cfg_queue = 2'h1;
      conv(HOT);
      conv(MID);
      conv(HOT);
      chk(1'b0, event_flag);
      cfg_queue = 2'h0;
      conv(HOT);
      sleep_request = 1'b1;
      conv(COLD);
      chk(1'b1, alert_oe);
      chk(HOT, temp_value);
      sleep_request = 1'b0;
      conv(COLD);
      chk(1'b0, alert_oe);
      rd(1'b1);
   endtask : t_run_reset
   task automatic t_int;
      cfg_mode = 1'b1;
      conv(HOT);
      chk(1'b1, alert_oe);
      rd(1'b0);
      chk(1'b0, event_flag);
      chk(1'b0, alert_oe);
      cfg_mode = 1'b0;
      cyc(1);
      cfg_mode = 1'b1;
      conv(COLD);
      chk(1'b0, event_flag);
      conv(HOT);
      chk(1'b1, event_flag);
      conv(COLD);
      chk(1'b1, alert_oe);
      rd(1'b1);
      conv(COLD);
      chk(1'b0, event_flag);
      conv(HOT);
      rd(1'b1);
      conv(HOT);
      chk(1'b0, event_flag);
      alert_mask = 1'b1;
      conv(COLD);
      chk(1'b1, event_flag);
      chk(1'b0, alert_oe);
      alert_mask = 1'b0;
      alert_polarity = 1'b1;
      cyc(3);
      chk(1'b0, alert_oe);
      alert_polarity = 1'b0;
      cyc(3);
      chk(1'b1, alert_oe);
      sleep_request = 1'b1;
      cyc(3);
      chk(1'b0, event_flag);
      chk(1'b0, alert_oe);
   endtask : t_int
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      cyc(12);
      rst_n = 1'b1;
      cyc(2);
      t_queue;
      t_run_reset;
      t_int;
      finish_test;
   end
   initial begin
      repeat (8000) @(posedge mclk);
      err_total++;
      finish_test;
   end
endmodule : testbench
